// file: src/plps_power_seq.sv
// top of the downstream port l2/l3 power sequencer with its config register
`timescale 1ns/10ps
`default_nettype none
module plps_power_seq (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire logic                        perst_n,
  input  wire logic                        cfg_wr,
  input  wire logic                        cfg_rd,
  input  wire logic [2:0]                  cfg_port,
  input  wire logic [11:0]                 cfg_addr,
  input  wire logic [3:0]                  cfg_be,
  input  wire logic [31:0]                 cfg_wdata,
  output logic      [31:0]                 cfg_rdata,
  output logic                             cfg_rd_valid,
  input  wire logic [plps_pkg::NUM_DS-1:0]   pme_ack_rx,
  input  wire logic [3*plps_pkg::NUM_DS-1:0] link_state,
  output logic      [plps_pkg::NUM_DS-1:0]   pme_turnoff_tx,
  output logic      [plps_pkg::NUM_DS-1:0]   ds_power_en,
  output logic      [plps_pkg::NUM_DS-1:0]   ds_reset_n,
  output logic      [2*plps_pkg::NUM_DS-1:0] func_dstate,
  output logic      [plps_pkg::NUM_DS-1:0]   aspm_l0s_en,
  output logic      [plps_pkg::NUM_DS-1:0]   aspm_l1_en,
  output logic      [plps_pkg::NUM_DS-1:0]   ltr_en,
  output logic      [plps_pkg::NUM_DS-1:0]   obff_en,
  output logic                             core_reset_n
);

  localparam int N = plps_pkg::NUM_DS;

  // ****************************************************************
  // control word layout, one per downstream port
  // ****************************************************************
  // bit 0      enter: send the turn-off message, reads zero
  // bit 1      power off: cut device power once in l2/l3, reads zero
  // bit 2      power on: restore power, device reset stays held, reads zero
  // bit 3      reset release: let the device out of reset, reads zero
  // bit 8      l2/l3 reached, sticky, write one to clear
  // bit 9      device power on
  // bit 10     device reset held
  // bits 14:12 sequencer state
  // bits 17:16 function power state, reads d3 while unpowered
  // bits 20:18 link power state as the link reports it
  // bit 21     aspm l0s enable
  // bit 22     aspm l1 enable
  // bit 23     latency tolerance reporting enable
  // bit 24     buffer flush/fill signalling enable
  // a field only changes when its own byte lane is enabled;
  // all other bits read zero and ignore writes

  logic         sys_rst_n;
  logic [N-1:0] wr_hit;
  logic [N-1:0] rd_hit;
  logic [N-1:0] done_v;
  logic [2:0]   state_v [N];
  logic [1:0]   dstate [N];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true when the access targets the control word of downstream port idx
  function automatic logic plps_hit(input logic [2:0] port, input logic [11:0] addr, input int idx);
    plps_hit = (port != plps_pkg::UP_PORT)
            && (port == 3'(idx + 1))
            && (addr == plps_pkg::L2L3_CTRL_OFF);
  endfunction : plps_hit

  // a written one in a command field, gated by its byte lane
  function automatic logic plps_wbit(input logic [31:0] data, input logic [3:0] be, input int pos);
    plps_wbit = be[pos / 8] && data[pos];
  endfunction : plps_wbit

  // ****************************************************************
  // fundamental reset
  // ****************************************************************
  // the pin is taken as synchronous; either reset holds every function
  assign sys_rst_n = reset_n && perst_n;

  // registered copy for the rest of the chip; it leaves reset one edge after the pins
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= 1'b1;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one-hot select of the addressed downstream port; the upstream port never hits
  always_comb begin
    for (int i = 0; i < N; i++) begin
      wr_hit[i] = cfg_wr && plps_hit(cfg_port, cfg_addr, i);
      rd_hit[i] = cfg_rd && plps_hit(cfg_port, cfg_addr, i);
    end
  end

  // ****************************************************************
  // software-owned fields
  // ****************************************************************
  // power state field: d0 to d3-hot; d3-cold follows from the port's power being cut
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      for (int i = 0; i < N; i++) begin
        dstate[i] <= plps_pkg::DSTATE_RESET;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit[i] && cfg_be[2]) begin
          dstate[i] <= cfg_wdata[plps_pkg::F_DSTATE_LO +: 2];
        end
      end
    end
  end

  // active state power management enables handed to the link layer
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      aspm_l0s_en <= '0;
      aspm_l1_en  <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit[i] && cfg_be[2]) begin
          aspm_l0s_en[i] <= cfg_wdata[plps_pkg::F_ASPM_L0S];
          aspm_l1_en[i]  <= cfg_wdata[plps_pkg::F_ASPM_L1];
        end
      end
    end
  end

  // platform power hints for the message layer; they sit in two byte lanes
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      ltr_en  <= '0;
      obff_en <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit[i] && cfg_be[2]) begin
          ltr_en[i] <= cfg_wdata[plps_pkg::F_LTR];
        end
        if (wr_hit[i] && cfg_be[3]) begin
          obff_en[i] <= cfg_wdata[plps_pkg::F_OBFF];
        end
      end
    end
  end

  // flatten the per-port power states onto the output bus
  always_comb begin
    for (int i = 0; i < N; i++) begin
      func_dstate[2*i +: 2] = dstate[i];
    end
  end

  // ****************************************************************
  // per-port sequencers
  // ****************************************************************
  // each port runs its own machine, so one port in l2/l3 leaves the others untouched
  // a full cycle runs active, turn-off sent, waiting for ack and l2/l3 ready,
  // l2/l3, power off, reset held after power returns, then active again;
  // a command written in the wrong step is dropped rather than queued
  for (genvar g = 0; g < N; g++) begin : g_port
    plps_port_if pif ();

    // command strobes, each a written one in its own bit and byte lane
    assign pif.enter       = wr_hit[g] && plps_wbit(cfg_wdata, cfg_be, plps_pkg::F_CMD_ENTER);
    assign pif.pwr_off     = wr_hit[g] && plps_wbit(cfg_wdata, cfg_be, plps_pkg::F_CMD_PWR_OFF);
    assign pif.pwr_on      = wr_hit[g] && plps_wbit(cfg_wdata, cfg_be, plps_pkg::F_CMD_PWR_ON);
    assign pif.rst_release = wr_hit[g] && plps_wbit(cfg_wdata, cfg_be, plps_pkg::F_CMD_RST_REL);
    assign pif.done_clr    = wr_hit[g] && plps_wbit(cfg_wdata, cfg_be, plps_pkg::F_DONE);

    // status back to the read path
    assign done_v[g]       = pif.done;
    assign state_v[g]      = pif.state;

    plps_port_seq u_seq (
      .clk_sys      (clk_sys),
      .reset_n      (sys_rst_n),
      .ctl          (pif.seq),
      .pme_ack      (pme_ack_rx[g]),
      .link_l2l3    (link_state[3*g +: 3] == plps_pkg::LINK_L2L3RDY),
      .turnoff_msg  (pme_turnoff_tx[g]),
      .dev_power_en (ds_power_en[g]),
      .dev_reset_n  (ds_reset_n[g])
    );
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // every read strobe is answered one cycle later, even where nothing is mapped
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      cfg_rd_valid <= 1'b0;
    end else begin
      cfg_rd_valid <= cfg_rd;
    end
  end

  // read data registered; the upstream port and unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (!sys_rst_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rdata <= 32'h0000_0000;
      for (int i = 0; i < N; i++) begin
        if (rd_hit[i]) begin
          cfg_rdata[plps_pkg::F_DONE]             <= done_v[i];
          cfg_rdata[plps_pkg::F_PWR]              <= ds_power_en[i];
          cfg_rdata[plps_pkg::F_RST]              <= !ds_reset_n[i];
          cfg_rdata[plps_pkg::F_STATE_LO +: 3]    <= state_v[i];
          cfg_rdata[plps_pkg::F_DSTATE_LO +: 2]   <= ds_power_en[i] ? dstate[i] : plps_pkg::DSTATE_D3;
          cfg_rdata[plps_pkg::F_LINK_LO +: 3]     <= link_state[3*i +: 3];
          cfg_rdata[plps_pkg::F_ASPM_L0S]         <= aspm_l0s_en[i];
          cfg_rdata[plps_pkg::F_ASPM_L1]          <= aspm_l1_en[i];
          cfg_rdata[plps_pkg::F_LTR]              <= ltr_en[i];
          cfg_rdata[plps_pkg::F_OBFF]             <= obff_en[i];
        end
      end
    end
  end

endmodule : plps_power_seq
`default_nettype wire

// file: src/plps_pkg.sv
// constants and types for the per-port l2/l3 power sequencer
package plps_pkg;

  // ****************************************************************
  // geometry and addressing
  // ****************************************************************
  localparam int          NUM_DS        = 5;      // downstream ports 1..5
  localparam logic [2:0]  UP_PORT       = 3'h0;   // upstream port number
  localparam logic [11:0] L2L3_CTRL_OFF = 12'h09C;

  // ****************************************************************
  // field positions of the l2/l3 control register
  // ****************************************************************
  localparam int F_CMD_ENTER   = 0;   // write 1: send turn-off message
  localparam int F_CMD_PWR_OFF = 1;   // write 1: stop device power
  localparam int F_CMD_PWR_ON  = 2;   // write 1: restore power, hold reset
  localparam int F_CMD_RST_REL = 3;   // write 1: release device reset
  localparam int F_DONE        = 8;   // sticky l2/l3 reached, write 1 to clear
  localparam int F_PWR         = 9;
  localparam int F_RST         = 10;
  localparam int F_STATE_LO    = 12;  // three bits of sequencer state
  localparam int F_DSTATE_LO   = 16;  // two bits of function power state
  localparam int F_LINK_LO     = 18;  // three bits of link power state
  localparam int F_ASPM_L0S    = 21;
  localparam int F_ASPM_L1     = 22;
  localparam int F_LTR         = 23;
  localparam int F_OBFF        = 24;

  // ****************************************************************
  // reset values and encodings
  // ****************************************************************
  localparam logic [1:0] DSTATE_RESET = 2'h0;  // d0
  localparam logic [1:0] DSTATE_D3    = 2'h3;  // d3-hot, or d3-cold once unpowered
  localparam logic       CTRL_RESET   = 1'b0;
  localparam logic [2:0] LINK_L0      = 3'h0;
  localparam logic [2:0] LINK_L0S     = 3'h1;
  localparam logic [2:0] LINK_L1      = 3'h2;
  localparam logic [2:0] LINK_L2L3RDY = 3'h3;
  localparam logic [2:0] LINK_L3      = 3'h4;

  // board-side fundamental reset hold time, kept for reference only; neither the design nor the bench reads it
  localparam int PERST_HOLD_MS = 100;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_TURNOFF,
    ST_WAIT_ACK,
    ST_L2L3,
    ST_POWER_OFF,
    ST_RESET_HOLD
  } plps_seq_state_t;

endpackage : plps_pkg

// file: src/plps_port_if.sv
// control and status carried between the register block and one port sequencer
`timescale 1ns/10ps
`default_nettype none
interface plps_port_if;
  logic                      enter;
  logic                      pwr_off;
  logic                      pwr_on;
  logic                      rst_release;
  logic                      done_clr;
  logic                      done;
  plps_pkg::plps_seq_state_t state;

  modport regs (output enter, output pwr_off, output pwr_on, output rst_release, output done_clr,
                input done, input state);
  modport seq  (input enter, input pwr_off, input pwr_on, input rst_release, input done_clr,
                output done, output state);
endinterface : plps_port_if
`default_nettype wire

// file: src/plps_port_seq.sv
// per-port l2/l3 entry and recovery sequencer
`timescale 1ns/10ps
`default_nettype none
module plps_port_seq (
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  plps_port_if.seq   ctl,
  input  wire logic  pme_ack,
  input  wire logic  link_l2l3,
  output logic       turnoff_msg,
  output logic       dev_power_en,
  output logic       dev_reset_n
);

  plps_pkg::plps_seq_state_t state;
  plps_pkg::plps_seq_state_t next_state;
  logic                      ack_seen;

  assign ctl.state = state;

  // ****************************************************************
  // state transitions
  // ****************************************************************
  // commands outside their own state are ignored, so a stray write never skips a step
  always_comb begin
    next_state = state;
    case (state)
      plps_pkg::ST_ACTIVE:     if (ctl.enter) next_state = plps_pkg::ST_TURNOFF;
      plps_pkg::ST_TURNOFF:    next_state = plps_pkg::ST_WAIT_ACK;
      plps_pkg::ST_WAIT_ACK:   if ((ack_seen || pme_ack) && link_l2l3) next_state = plps_pkg::ST_L2L3;
      plps_pkg::ST_L2L3:       if (ctl.pwr_off) next_state = plps_pkg::ST_POWER_OFF;
      plps_pkg::ST_POWER_OFF:  if (ctl.pwr_on) next_state = plps_pkg::ST_RESET_HOLD;
      plps_pkg::ST_RESET_HOLD: if (ctl.rst_release) next_state = plps_pkg::ST_ACTIVE;
      default:                 next_state = plps_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= plps_pkg::ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // acknowledge capture
  // ****************************************************************
  // the ack may arrive before the link settles, so it is remembered until then
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack_seen <= 1'b0;
    end else if (state == plps_pkg::ST_TURNOFF) begin
      ack_seen <= 1'b0;
    end else if (state == plps_pkg::ST_WAIT_ACK && pme_ack) begin
      ack_seen <= 1'b1;
    end
  end

  // sticky progress flag; a new arrival beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctl.done <= 1'b0;
    end else if (state == plps_pkg::ST_WAIT_ACK && next_state == plps_pkg::ST_L2L3) begin
      ctl.done <= 1'b1;
    end else if (ctl.done_clr) begin
      ctl.done <= 1'b0;
    end
  end

  // ****************************************************************
  // port outputs
  // ****************************************************************
  // one-cycle message request aimed at this port only
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      turnoff_msg <= 1'b0;
    end else begin
      turnoff_msg <= (state == plps_pkg::ST_ACTIVE) && ctl.enter;
    end
  end

  // power and reset follow the next state so they change with it
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dev_power_en <= 1'b1;
      dev_reset_n  <= 1'b1;
    end else begin
      dev_power_en <= (next_state != plps_pkg::ST_POWER_OFF);
      dev_reset_n  <= (next_state != plps_pkg::ST_RESET_HOLD)
                   && (next_state != plps_pkg::ST_POWER_OFF);
    end
  end

endmodule : plps_port_seq
`default_nettype wire

// file: bench/plps_power_seq_sva.sv
// checker for the l2/l3 power sequencer top ports
`timescale 1ns/10ps
`default_nettype none
module plps_power_seq_chk (
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire logic                          perst_n,
  input wire logic                          cfg_wr,
  input wire logic                          cfg_rd,
  input wire logic [2:0]                    cfg_port,
  input wire logic [11:0]                   cfg_addr,
  input wire logic [31:0]                   cfg_wdata,
  input wire logic [31:0]                   cfg_rdata,
  input wire logic                          cfg_rd_valid,
  input wire logic [plps_pkg::NUM_DS-1:0]   pme_turnoff_tx,
  input wire logic [plps_pkg::NUM_DS-1:0]   ds_power_en,
  input wire logic [plps_pkg::NUM_DS-1:0]   ds_reset_n,
  input wire logic                          core_reset_n
);
  // ****************************************************************
  // sequencer and register checks
  // ****************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a turn-off goes to one port, as a single pulse, and only from a write
  turnoff_one_hot_a: assert property ($onehot0(pme_turnoff_tx))
    else $error("turn-off sent to several ports");
  turnoff_pulse_a: assert property (|pme_turnoff_tx |=> (pme_turnoff_tx & $past(pme_turnoff_tx)) == '0)
    else $error("turn-off held longer than one cycle");
  turnoff_cause_a: assert property (|pme_turnoff_tx |-> $past(cfg_wr) && $past(cfg_wdata[0])
    && $past(cfg_addr) == 12'h09C && pme_turnoff_tx == (5'h01 << ($past(cfg_port) - 3'h1)))
    else $error("turn-off without matching enter write");
  read_answer_a: assert property (cfg_rd |=> cfg_rd_valid)
    else $error("read not answered");
  upstream_read_a: assert property (cfg_rd && cfg_port == 3'h0 |=> cfg_rdata == 32'h0)
    else $error("upstream port shows the control register");
  core_reset_a: assert property (!perst_n |=> !core_reset_n)
    else $error("core left reset while pin low");
  unpowered_reset_a: assert property ((~ds_power_en & ds_reset_n) == '0)
    else $error("device out of reset without power");
  power_off_cause_a: assert property (|(~ds_power_en & $past(ds_power_en)) |-> $past(cfg_wr) && $past(cfg_wdata[1]))
    else $error("power dropped without a power-off write");
  reset_release_a: assert property (disable iff (!reset_n || !perst_n)
    |(ds_reset_n & ~$past(ds_reset_n)) |-> $past(cfg_wr) && $past(cfg_wdata[3]))
    else $error("device reset released without a write");
  // main scenarios reached
  cover property (|pme_turnoff_tx);
  cover property (|(~ds_power_en));
  cover property (cfg_rd_valid && cfg_rdata[8]);
endmodule : plps_power_seq_chk
bind plps_power_seq plps_power_seq_chk plps_power_seq_chk_i (.clk_sys, .reset_n, .perst_n, .cfg_wr, .cfg_rd,
  .cfg_port, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .pme_turnoff_tx, .ds_power_en, .ds_reset_n,
  .core_reset_n);
`default_nettype wire

// file: bench/plps_dev_model.sv
// behavioural downstream devices, one per port
`timescale 1ns/10ps
`default_nettype none
module plps_dev_model (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic [plps_pkg::NUM_DS-1:0]   turnoff,
  input  wire logic [plps_pkg::NUM_DS-1:0]   power_en,
  output logic      [plps_pkg::NUM_DS-1:0]   ack,
  output logic      [3*plps_pkg::NUM_DS-1:0] link
);
  logic [3:0] cnt [plps_pkg::NUM_DS];
  // higher ports answer more slowly; ack comes one cycle before l2/l3 ready
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < plps_pkg::NUM_DS; i++) begin
      ack[i] <= 1'b0;
      if (!reset_n) begin
        cnt[i]        <= 4'h0;
        link[3*i +: 3] <= plps_pkg::LINK_L0;
      end else if (!power_en[i]) begin
        link[3*i +: 3] <= plps_pkg::LINK_L3;  // unpowered link sits in l3
      end else if (link[3*i +: 3] == plps_pkg::LINK_L3) begin
        link[3*i +: 3] <= plps_pkg::LINK_L0;  // retrains once power is back
      end else if (turnoff[i]) begin
        cnt[i] <= 4'(2 + 2 * i);
      end else if (cnt[i] != 4'h0) begin
        cnt[i] <= cnt[i] - 4'h1;
        if (cnt[i] == 4'h2) ack[i] <= 1'b1;
        if (cnt[i] == 4'h1) link[3*i +: 3] <= plps_pkg::LINK_L2L3RDY;
      end
    end
  end
endmodule : plps_dev_model
`default_nettype wire

// file: bench/plps_power_seq_test.sv
// self-checking bench for the l2/l3 power sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module plps_power_seq_test;
  logic clk_sys, reset_n, perst_n, cfg_wr, cfg_rd, cfg_rd_valid, core_reset_n;
  logic [2:0]  cfg_port;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic [4:0]  ack, tx, pwr, rst, l0s, l1, ltr, obff;
  logic [3:0]  be;
  logic [14:0] link;
  logic [9:0]  dst;
  int failures, checks;
  // ****************************************************************
  // design, devices, clock
  // ****************************************************************
  plps_power_seq plps_power_seq_i (.clk_sys, .reset_n, .perst_n, .cfg_wr, .cfg_rd, .cfg_port, .cfg_addr,
    .cfg_be(be), .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .pme_ack_rx(ack), .link_state(link),
    .pme_turnoff_tx(tx), .ds_power_en(pwr), .ds_reset_n(rst), .func_dstate(dst), .aspm_l0s_en(l0s),
    .aspm_l1_en(l1), .ltr_en(ltr), .obff_en(obff), .core_reset_n);
  plps_dev_model plps_dev_model_i (.clk_sys, .reset_n, .turnoff(tx), .power_en(pwr), .ack, .link);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // one write; outputs of the acting edge are settled on return
  task automatic wr(input logic [2:0] p, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    cfg_wr    <= 1'b1;
    cfg_port  <= p;
    cfg_addr  <= a;
    cfg_wdata <= v;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] p, input logic [11:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    cfg_rd   <= 1'b1;
    cfg_port <= p;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_rd_valid, 1'b1)
    v = cfg_rdata;
  endtask : rd
  task automatic rd_chk(input logic [2:0] p, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(p, a, v);
    `CHK(v, e)
  endtask : rd_chk
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // hang guard, far beyond the few dozen cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    results();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {cfg_wr, cfg_rd, reset_n, perst_n} = 4'h1;
    {cfg_port, cfg_addr, cfg_wdata, d} = '0;
    be = 4'hF;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(core_reset_n, 1'b1)
    wr(3'h2, 12'h09C, 32'h2);  // power off refused while active
    rd_chk(3'h2, 12'h09C, 32'h0000_0200);
    wr(3'h0, 12'h09C, 32'h1);
    `CHK(tx, 5'h00)
    wr(3'h1, 12'h0A0, 32'h1);
    `CHK(tx, 5'h00)
    rd_chk(3'h0, 12'h09C, 32'h0);
    rd_chk(3'h1, 12'h0A0, 32'h0);
    $display("test access done");
    wr(3'h2, 12'h09C, 32'h1);
    `CHK(tx, 5'h02)
    for (int k = 0; k < 20 && !d[8]; k++) rd(3'h2, 12'h09C, d);
    rd_chk(3'h2, 12'h09C, 32'h000C_3300);
    rd_chk(3'h3, 12'h09C, 32'h0000_0200);
    wr(3'h2, 12'h09C, 32'h2);
    `CHK(pwr, 5'h1D)
    `CHK(rst, 5'h1D)
    rd_chk(3'h2, 12'h09C, 32'h0013_4500);
    wr(3'h2, 12'h09C, 32'h8);  // release refused while unpowered
    `CHK(rst, 5'h1D)
    wr(3'h2, 12'h09C, 32'h4);
    `CHK(pwr, 5'h1F)
    `CHK(rst, 5'h1D)
    wr(3'h2, 12'h09C, 32'h108);
    `CHK(rst, 5'h1F)
    rd_chk(3'h2, 12'h09C, 32'h0000_0200);
    $display("test l2l3 done");
    for (int k = 0; k < 4; k++) begin
      wr(3'h4, 12'h09C, 32'h01E0_0000 | (32'(k) << 16));
      `CHK(dst, 10'(k) << 6)
    end
    be <= 4'h3;  // upper byte lanes off: power state and enables must hold
    wr(3'h4, 12'h09C, 32'h0000_0000);
    be <= 4'hF;
    `CHK(dst, 10'h0C0)
    `CHK({l0s, l1}, 10'h108)
    `CHK({ltr, obff}, 10'h108)
    rd_chk(3'h4, 12'h09C, 32'h01E3_0200);
    $display("test fields done");
    @(posedge clk_sys);
    perst_n <= 1'b0;  // held a few cycles only; the board-side hold is far longer
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(core_reset_n, 1'b0)
    `CHK(dst, 10'h000)
    perst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(core_reset_n, 1'b1)
    $display("test perst done");
    results();
  end
endmodule : plps_power_seq_test
`default_nettype wire
